//--- art3_cfg.svh
// Constants for the auto-reload timer three block
// What this block does
// - Split bit picks 16-bit or dual 8-bit
// - Run bit gates counting when unsplit
// - Split: run gates high byte only
// - Select codes pick external count clock
// - Select codes pick capture trigger source
// - Per-byte choice: external or system clock
// - External sources synchronised before use
// - Reload low register at 0x92
// - Reload high register at 0x93
// - Count low register at 0x94
// - Count high register at 0x95
// - High overflow sets sticky high flag
// - Low byte rollover sets low flag
// - Low overflow with enables raises request
// - Capture enable selects capture mode
`ifndef ART3_CFG_SVH
`define ART3_CFG_SVH
// ----------------------------------------
// Register addresses and fields
// ----------------------------------------
`define ART3_ADDR_RELOAD_LOW 8'h92
`define ART3_ADDR_RELOAD_HIGH 8'h93
`define ART3_ADDR_COUNT_LOW 8'h94
`define ART3_ADDR_COUNT_HIGH 8'h95
`define ART3_RESET_BYTE 8'h00
`define ART3_SEL_RTC 2'h3
`define ART3_SEL_OSC_TRIG 1
// ----------------------------------------
// Timing
// ----------------------------------------
`define ART3_SYSTEM_CLOCK_DIV 12
`define ART3_DIV_W 4
`endif

//--- art3_pkg.sv
// Types for the auto-reload timer three block
package art3_pkg;
  typedef struct packed {
    logic split_select;
    logic run_control_bit;
    logic [1:0] clock_and_trigger_select;
    logic capture_enable;
    logic low_overflow_irq_enable;
    logic high_byte_clock_choice;
    logic low_byte_clock_choice;
  } art3_ctrl_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } art3_sfr_t;
  typedef enum logic [1:0] {
    ART3_UNSPLIT = 2'b01,
    ART3_SPLIT = 2'b10
  } art3_mode_t;
endpackage

//--- art3_sync.sv
// Two-flop synchroniser with rising-edge pulse
module art3_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Source and pulse
  input wire logic src,
  output logic rise
);
  logic s1_r, s2_r, s3_r;
  logic s1_nxt, s2_nxt, s3_nxt, rise_nxt;
  always_comb begin
    s1_nxt = src;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    rise_nxt = s2_r & ~s3_r;
  end
  // First flop only feeds the second
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      rise <= 1'b0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      rise <= rise_nxt;
    end
  end
endmodule

//--- art3_timer.sv
// Auto-reload timer three, top level
`include "art3_cfg.svh"
module art3_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Special-function register port
  input wire art3_pkg::art3_sfr_t sfr,
  output logic [7:0] rdata,
  // Control bits held outside this block
  input wire art3_pkg::art3_ctrl_t ctrl,
  input wire logic timer_irq_global_enable,
  input wire logic clear_high_flag,
  input wire logic clear_low_flag,
  // Raw external sources
  input wire logic rtc_osc,
  input wire logic ext_osc_div8,
  // Status
  output logic high_overflow_flag,
  output logic low_overflow_flag,
  output logic irq_low,
  output logic capture_trigger,
  output logic capture_active
);
  // ----------------------------------------
  // Source synchronisers
  // ----------------------------------------
  logic rtc_rise, osc_rise;
  art3_sync u_sync_rtc (.clk(clk), .nrst(nrst), .src(rtc_osc), .rise(rtc_rise));
  art3_sync u_sync_osc (.clk(clk), .nrst(nrst), .src(ext_osc_div8), .rise(osc_rise));

  // ----------------------------------------
  // System clock divided by twelve
  // ----------------------------------------
  logic [`ART3_DIV_W-1:0] div_r, div_nxt;
  logic div_tick;
  always_comb begin
    div_tick = (div_r == `ART3_DIV_W'(`ART3_SYSTEM_CLOCK_DIV - 1));
    div_nxt = div_tick ? '0 : div_r + `ART3_DIV_W'(1);
  end
  always_ff @(posedge clk) begin
    if (!nrst) div_r <= '0;
    else div_r <= div_nxt;
  end

  // ----------------------------------------
  // Source selection
  // ----------------------------------------
  logic ext_tick, trig_tick, tick_low, tick_high, split;
  art3_pkg::art3_mode_t mode;
  always_comb begin
    ext_tick = (ctrl.clock_and_trigger_select == `ART3_SEL_RTC) ? rtc_rise : div_tick;
    trig_tick = ctrl.clock_and_trigger_select[`ART3_SEL_OSC_TRIG] ? osc_rise : rtc_rise;
    // Shared external source for both bytes
    tick_low = ctrl.low_byte_clock_choice ? 1'b1 : ext_tick;
    tick_high = ctrl.high_byte_clock_choice ? 1'b1 : ext_tick;
    mode = ctrl.split_select ? art3_pkg::ART3_SPLIT : art3_pkg::ART3_UNSPLIT;
    split = (mode == art3_pkg::ART3_SPLIT);
  end

  // ----------------------------------------
  // Registers and counter
  // ----------------------------------------
  logic [7:0] rl_lo_r, rl_hi_r, cnt_lo_r, cnt_hi_r;
  logic [7:0] rl_lo_nxt, rl_hi_nxt, cnt_lo_nxt, cnt_hi_nxt, rdata_nxt;
  logic fh_nxt, fl_nxt, irq_nxt, lo_ovf, hi_ovf, lo_en, hi_en;
  always_comb begin
    rl_lo_nxt = rl_lo_r;
    rl_hi_nxt = rl_hi_r;
    cnt_lo_nxt = cnt_lo_r;
    cnt_hi_nxt = cnt_hi_r;
    lo_ovf = 1'b0;
    hi_ovf = 1'b0;
    lo_en = 1'b0;
    hi_en = 1'b0;
    case (mode)
      art3_pkg::ART3_UNSPLIT: begin
        lo_en = ctrl.run_control_bit & tick_low;
        if (lo_en) begin
          if (cnt_lo_r == 8'hff) begin
            lo_ovf = 1'b1;
            if (cnt_hi_r == 8'hff) begin
              hi_ovf = 1'b1;
              cnt_lo_nxt = rl_lo_r;
              cnt_hi_nxt = rl_hi_r;
            end else begin
              cnt_lo_nxt = 8'h00;
              cnt_hi_nxt = cnt_hi_r + 8'h01;
            end
          end else begin
            cnt_lo_nxt = cnt_lo_r + 8'h01;
          end
        end
      end
      art3_pkg::ART3_SPLIT: begin
        lo_en = tick_low;
        hi_en = ctrl.run_control_bit & tick_high;
        if (lo_en) begin
          lo_ovf = (cnt_lo_r == 8'hff);
          cnt_lo_nxt = lo_ovf ? rl_lo_r : cnt_lo_r + 8'h01;
        end
        if (hi_en) begin
          hi_ovf = (cnt_hi_r == 8'hff);
          cnt_hi_nxt = hi_ovf ? rl_hi_r : cnt_hi_r + 8'h01;
        end
      end
      default: begin
        cnt_lo_nxt = cnt_lo_r;
      end
    endcase
    // Software write wins over counting in the same cycle
    if (sfr.wr) begin
      case (sfr.addr)
        `ART3_ADDR_RELOAD_LOW: rl_lo_nxt = sfr.wdata;
        `ART3_ADDR_RELOAD_HIGH: rl_hi_nxt = sfr.wdata;
        `ART3_ADDR_COUNT_LOW: cnt_lo_nxt = sfr.wdata;
        `ART3_ADDR_COUNT_HIGH: cnt_hi_nxt = sfr.wdata;
        default: rl_lo_nxt = rl_lo_nxt;
      endcase
    end
    case (sfr.addr)
      `ART3_ADDR_RELOAD_LOW: rdata_nxt = rl_lo_r;
      `ART3_ADDR_RELOAD_HIGH: rdata_nxt = rl_hi_r;
      `ART3_ADDR_COUNT_LOW: rdata_nxt = cnt_lo_r;
      `ART3_ADDR_COUNT_HIGH: rdata_nxt = cnt_hi_r;
      default: rdata_nxt = 8'h00;
    endcase
    // Set beats clear so no overflow is lost
    fh_nxt = hi_ovf | (high_overflow_flag & ~clear_high_flag);
    fl_nxt = lo_ovf | (low_overflow_flag & ~clear_low_flag);
    irq_nxt = fl_nxt & ctrl.low_overflow_irq_enable & timer_irq_global_enable;
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rl_lo_r <= `ART3_RESET_BYTE;
      rl_hi_r <= `ART3_RESET_BYTE;
      cnt_lo_r <= `ART3_RESET_BYTE;
      cnt_hi_r <= `ART3_RESET_BYTE;
      rdata <= 8'h00;
      high_overflow_flag <= 1'b0;
      low_overflow_flag <= 1'b0;
      irq_low <= 1'b0;
      capture_trigger <= 1'b0;
      capture_active <= 1'b0;
    end else begin
      rl_lo_r <= rl_lo_nxt;
      rl_hi_r <= rl_hi_nxt;
      cnt_lo_r <= cnt_lo_nxt;
      cnt_hi_r <= cnt_hi_nxt;
      rdata <= rdata_nxt;
      high_overflow_flag <= fh_nxt;
      low_overflow_flag <= fl_nxt;
      irq_low <= irq_nxt;
      capture_trigger <= ctrl.capture_enable & trig_tick;
      capture_active <= ctrl.capture_enable;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Counting and reload
  a_stop_holds: assert property (@(posedge clk) disable iff (!nrst)
    (!ctrl.split_select && !ctrl.run_control_bit && !sfr.wr) |=> $stable(cnt_lo_r))
    else $error("count moved while stopped");
  a_split_low_runs: assert property (@(posedge clk) disable iff (!nrst)
    (ctrl.split_select && ctrl.low_byte_clock_choice && !sfr.wr && cnt_lo_r != 8'hff)
    |=> cnt_lo_r == $past(cnt_lo_r) + 8'h01)
    else $error("low byte did not count in split");
  a_split_high_stop: assert property (@(posedge clk) disable iff (!nrst)
    (split && !ctrl.run_control_bit && !sfr.wr) |=> $stable(cnt_hi_r))
    else $error("high byte moved while stopped in split");
  a_unsplit_carry: assert property (@(posedge clk) disable iff (!nrst)
    (lo_ovf && !split && !sfr.wr && cnt_hi_r != 8'hff)
    |=> (cnt_lo_r == 8'h00) && (cnt_hi_r == $past(cnt_hi_r) + 8'h01))
    else $error("carry into high byte lost");
  a_reload_16: assert property (@(posedge clk) disable iff (!nrst)
    (hi_ovf && !ctrl.split_select && !sfr.wr) |=> cnt_hi_r == $past(rl_hi_r))
    else $error("no reload on overflow");
  a_split_reload_low: assert property (@(posedge clk) disable iff (!nrst)
    (lo_ovf && split && !sfr.wr) |=> cnt_lo_r == $past(rl_lo_r))
    else $error("low byte not reloaded in split");
  // Register access
  a_reload_reg: assert property (@(posedge clk) disable iff (!nrst)
    (sfr.wr && sfr.addr == `ART3_ADDR_RELOAD_LOW) |=> rl_lo_r == $past(sfr.wdata))
    else $error("reload low write lost");
  a_reload_high_reg: assert property (@(posedge clk) disable iff (!nrst)
    (sfr.wr && sfr.addr == `ART3_ADDR_RELOAD_HIGH) |=> rl_hi_r == $past(sfr.wdata))
    else $error("reload high write lost");
  a_count_low_reg: assert property (@(posedge clk) disable iff (!nrst)
    (sfr.wr && sfr.addr == `ART3_ADDR_COUNT_LOW) |=> cnt_lo_r == $past(sfr.wdata))
    else $error("count low write lost");
  a_count_high_reg: assert property (@(posedge clk) disable iff (!nrst)
    (sfr.wr && sfr.addr == `ART3_ADDR_COUNT_HIGH) |=> cnt_hi_r == $past(sfr.wdata))
    else $error("count high write lost");
  a_count_read: assert property (@(posedge clk) disable iff (!nrst)
    (sfr.addr == `ART3_ADDR_COUNT_HIGH && !sfr.wr) |=> rdata == $past(cnt_hi_r))
    else $error("count high read wrong");
  a_read_unmapped: assert property (@(posedge clk) disable iff (!nrst)
    (sfr.addr < `ART3_ADDR_RELOAD_LOW || sfr.addr > `ART3_ADDR_COUNT_HIGH)
    |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  // Sticky flags, request and capture
  a_low_flag_set: assert property (@(posedge clk) disable iff (!nrst)
    lo_ovf |=> low_overflow_flag)
    else $error("low flag missed");
  a_high_flag_set: assert property (@(posedge clk) disable iff (!nrst)
    hi_ovf |=> high_overflow_flag)
    else $error("high flag missed");
  a_low_flag_hold: assert property (@(posedge clk) disable iff (!nrst)
    (low_overflow_flag && !clear_low_flag) |=> low_overflow_flag)
    else $error("low flag dropped by itself");
  a_high_flag_hold: assert property (@(posedge clk) disable iff (!nrst)
    (high_overflow_flag && !clear_high_flag) |=> high_overflow_flag)
    else $error("high flag dropped by itself");
  a_irq_low: assert property (@(posedge clk) disable iff (!nrst)
    irq_low |-> (low_overflow_flag && $past(ctrl.low_overflow_irq_enable)
      && $past(timer_irq_global_enable)))
    else $error("request without flag and enables");
  a_irq_raise: assert property (@(posedge clk) disable iff (!nrst)
    (low_overflow_flag && !clear_low_flag && ctrl.low_overflow_irq_enable
      && timer_irq_global_enable) |=> irq_low)
    else $error("request missing");
  a_trig_needs_enable: assert property (@(posedge clk) disable iff (!nrst)
    !ctrl.capture_enable |=> !capture_trigger)
    else $error("trigger outside capture mode");
  a_capture_level: assert property (@(posedge clk) disable iff (!nrst)
    ctrl.capture_enable |=> capture_active)
    else $error("capture mode not shown");
endmodule

//--- art3_timer_bench.sv
// Self-checking testbench for the auto-reload timer three block
module art3_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Stimulus and observation
  // ----------------------------------------
  logic clk, nrst, glb, clr_h, clr_l, rtc, osc, got;
  art3_pkg::art3_sfr_t sfr;
  art3_pkg::art3_ctrl_t ctrl;
  logic [7:0] rdata, v;
  logic hf, lf, irq, trig, cap;
  int bad_count = 0;
  int num_checks = 0;
  art3_timer u_art3_timer (.clk(clk), .nrst(nrst), .sfr(sfr), .rdata(rdata), .ctrl(ctrl),
    .timer_irq_global_enable(glb), .clear_high_flag(clr_h), .clear_low_flag(clr_l),
    .rtc_osc(rtc), .ext_osc_div8(osc), .high_overflow_flag(hf), .low_overflow_flag(lf),
    .irq_low(irq), .capture_trigger(trig), .capture_active(cap));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    sfr.wr <= 1'b0;
  endtask
  // Data registered one edge after the address, taken at the next edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr.addr <= a;
    sfr.rd <= 1'b1;
    @(posedge clk);
    sfr.rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic src_edge(input logic use_rtc);
    @(posedge clk);
    if (use_rtc) rtc <= 1'b1; else osc <= 1'b1;
    got = 1'b0;
    repeat (8) begin
      @(posedge clk);
      rtc <= 1'b0;
      osc <= 1'b0;
      if (trig === 1'b1) got = 1'b1;
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // Clock, watchdog, tests
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Tests take well under 2000 cycles
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
  initial begin
    nrst = 1'b0; sfr = '0; ctrl = '0; glb = 1'b0;
    clr_h = 1'b0; clr_l = 1'b0; rtc = 1'b0; osc = 1'b0;
    wait_cyc(8);
    nrst <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(8'h92 + i[7:0], v);
      chk(v, 8'h00);
    end
    // Stopped timer keeps written values
    for (int i = 0; i < 5; i++) begin
      wr(8'h92 + i[7:0], 8'h11 * (i[7:0] + 8'h01));
      wait_cyc(20);
      rd(8'h92 + i[7:0], v);
      chk(v, (i == 4) ? 8'h00 : 8'h11 * (i[7:0] + 8'h01));
    end
    $display("test registers done");
    wr(8'h92, 8'h34); wr(8'h93, 8'h12); wr(8'h94, 8'hfd); wr(8'h95, 8'hff);
    ctrl.high_byte_clock_choice <= 1'b1;
    ctrl.low_byte_clock_choice <= 1'b1;
    ctrl.run_control_bit <= 1'b1;
    wait_cyc(10);
    ctrl.run_control_bit <= 1'b0;
    rd(8'h95, v);
    chk(v, 8'h12);
    chk(hf, 1'b1);
    chk(lf, 1'b1);
    clr_h <= 1'b1; clr_l <= 1'b1;
    wait_cyc(1);
    clr_h <= 1'b0; clr_l <= 1'b0;
    wait_cyc(2);
    chk({hf, lf}, 2'b00);
    $display("test unsplit overflow done");
    ctrl.split_select <= 1'b1;
    ctrl.low_overflow_irq_enable <= 1'b1;
    glb <= 1'b1;
    wr(8'h95, 8'h10); wr(8'h94, 8'hfe);
    wait_cyc(10);
    rd(8'h95, v);
    chk(v, 8'h10);
    chk({hf, lf, irq}, 3'b011);
    glb <= 1'b0;
    wait_cyc(3);
    chk(irq, 1'b0);
    $display("test split done");
    ctrl <= '0;
    wr(8'h94, 8'h00); wr(8'h95, 8'h00);
    ctrl.run_control_bit <= 1'b1;
    wait_cyc(120);
    ctrl.run_control_bit <= 1'b0;
    rd(8'h94, v);
    chk(v, 8'h0a);
    wr(8'h94, 8'h00);
    ctrl.clock_and_trigger_select <= 2'h3;
    ctrl.run_control_bit <= 1'b1;
    for (int i = 0; i < 4; i++) src_edge(1'b1);
    ctrl.run_control_bit <= 1'b0;
    rd(8'h94, v);
    chk(v, 8'h04);
    // Split: one external edge rolls both bytes
    ctrl.split_select <= 1'b1;
    ctrl.run_control_bit <= 1'b1;
    wr(8'h95, 8'hff); wr(8'h94, 8'hff);
    clr_l <= 1'b1;
    wait_cyc(1);
    clr_l <= 1'b0;
    src_edge(1'b1);
    ctrl.run_control_bit <= 1'b0;
    rd(8'h94, v);
    chk(v, 8'h34);
    rd(8'h95, v);
    chk(v, 8'h12);
    chk({hf, lf}, 2'b11);
    $display("test clock select done");
    ctrl.clock_and_trigger_select <= 2'h1;
    ctrl.capture_enable <= 1'b1;
    wait_cyc(3);
    chk(cap, 1'b1);
    src_edge(1'b1);
    chk(got, 1'b1);
    ctrl.clock_and_trigger_select <= 2'h2;
    src_edge(1'b0);
    chk(got, 1'b1);
    src_edge(1'b1);
    chk(got, 1'b0);
    $display("test capture done");
    wrap_up();
  end
endmodule
